// ==== hdl/mcmb_top.sv ====
`timescale 1ns/100ps
`include "mcmb_map.svh"
// How it works
// [R1] trim 0/3 none, 1 plus, 2 minus
// [R2] nominal modifier selects one of four coefficients
// [R3] gain bit adds gain of eight
// [R4] threshold bit picks 12.5 or 6.25 percent
// [R5] stepper bit picks 31.25 or 156.25 ms
// [R6] highest field address is field MSB
// [R7] fifty-six config bits, address 55 reserved
// [R8] eight mode bits, cleared only by power-on or system clear
// [R9] bit 0 starts RC oscillator
// [R10] bit 1 turns motor pins into pump
// [R11] bit 4 picks channel 2 untampered
// [R12] bit 5 sources config from latches
// [R13] bit 5 disconnects fuse sense amplifiers
// [R14] bit 6 also writes fuses
// [R15] 0xFF toggles record order, not stored
// [R16] host resends swap before each read
// [R17] system clear acts at select idle
// [R18] during system clear only swap accepted
// [R19] host holds bit 5 under programming voltage
// [R20] six-bit address equals bit index
// [R21] all serial lines high means idle
// [R22] reserved mode bits, address 55 read zero
// [R23] command byte: value, 111, index, don't-care
module mcmb_top #(
  parameter int STEP_SHORT_CYC = `MCMB_STEP_SHORT_NS / `MCMB_CLK_NS,
  parameter int STEP_LONG_CYC = `MCMB_STEP_LONG_NS / `MCMB_CLK_NS,
  parameter logic [15:0] PUMP_HALF = `MCMB_PUMP_HALF_CYC
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SERIAL_SELECT_N,
  input wire logic SERIAL_MODE_LINE,
  input wire logic SERIAL_CLOCK_PIN,
  input wire logic REMOTE_RESET_REQ,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_BYTE,
  input wire mcmb_pkg::mcmb_bitwr_t CFG_WR,
  input wire logic [`MCMB_CFG_BITS-1:0] FUSE_BITS,
  input wire logic RECORD_READ_DONE,
  input wire logic TAMPER_EN,
  input wire logic STEP_REQ,
  output mcmb_pkg::mcmb_cfg_t CFG_OUT,
  output logic [`MCMB_CFG_BITS-1:0] CFG_BITS,
  output mcmb_pkg::mcmb_adj_t OSC_ADJ,
  output logic [15:0] NOMINAL_COEFF,
  output logic [3:0] EXTRA_CURRENT_GAIN,
  output logic [10:0] TAMPER_THRESH,
  output logic [7:0] MODE_RECORD,
  output logic RECORD_SWAP,
  output logic RC_OSC_START,
  output logic CURRENT_CHANNEL_PICK,
  output logic FUSE_SENSE_OFF,
  output mcmb_pkg::mcmb_bitwr_t FUSE_WR,
  output logic MOTOR_OUT_POS,
  output logic MOTOR_OUT_NEG,
  output logic SYSTEM_SIGNAL_CLEAR
);
  import mcmb_pkg::*;

  // ----------------------------------------
  // serial idle and command decode
  // ----------------------------------------
  logic idle;
  logic sel_n_q_r;
  logic sel_rise;
  logic cmd_ok;
  logic cmd_take;
  logic cmd_swap;
  logic cmd_mode;
  logic [2:0] cmd_idx;
  logic cmd_val;
  logic sys_clr_r;

  assign idle = SERIAL_SELECT_N & SERIAL_MODE_LINE & SERIAL_CLOCK_PIN; // [R21]
  assign sel_rise = SERIAL_SELECT_N & ~sel_n_q_r;
  assign cmd_ok = CMD_VALID & ~idle & ~SERIAL_SELECT_N; // [R21]
  assign cmd_idx = CMD_BYTE[3:1]; // [R23]
  assign cmd_val = CMD_BYTE[`MCMB_CMD_VAL_BIT]; // [R23]
  assign cmd_swap = cmd_ok & (CMD_BYTE[7:1] == 7'(`MCMB_CMD_SWAP >> 1)); // [R15]
  assign cmd_take = cmd_ok & (CMD_BYTE[6:4] == `MCMB_CMD_TAG) & ~sys_clr_r; // [R23] [R18]
  assign cmd_mode = cmd_take & (cmd_idx != MCMB_M_SWAP);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_n_q_r <= 1'b1;
    end else begin
      sel_n_q_r <= SERIAL_SELECT_N;
    end
  end

  // ----------------------------------------
  // mode record
  // ----------------------------------------
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;

  always_comb begin
    mode_nxt = mode_r;
    if (cmd_mode) begin
      mode_nxt[cmd_idx] = cmd_val; // [R9] [R10] [R11] [R12] [R14]
    end
    mode_nxt = mode_nxt & ~`MCMB_MODE_RSVD_MASK; // [R22]
    if (sys_clr_r && sel_rise) begin
      mode_nxt = `MCMB_MODE_RESET; // [R17]
    end
  end

  // remote reset is deliberately not a term here
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_r <= `MCMB_MODE_RESET; // [R8]
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // system clear latch
  // ----------------------------------------
  logic sysclr_wr;
  assign sysclr_wr = CFG_WR.wr & (CFG_WR.addr == `MCMB_SYSCLR_ADDR);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sys_clr_r <= 1'b0;
    end else if (sys_clr_r && sel_rise) begin
      sys_clr_r <= 1'b0; // [R17]
    end else if (sysclr_wr && !sys_clr_r) begin
      sys_clr_r <= CFG_WR.data;
    end
  end

  // ----------------------------------------
  // record order swap
  // ----------------------------------------
  logic swap_r;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      swap_r <= 1'b0;
    end else if (cmd_swap) begin
      swap_r <= ~swap_r; // [R15]
    end else if (RECORD_READ_DONE || REMOTE_RESET_REQ) begin
      swap_r <= 1'b0; // [R15] [R16]
    end
  end

  // ----------------------------------------
  // shadow latches and fuse path
  // ----------------------------------------
  logic cfg_ok;
  logic [`MCMB_CFG_BITS-1:0] shadow;
  logic [`MCMB_CFG_BITS-1:0] eff;
  logic fuse_wr_nxt;

  assign cfg_ok = CFG_WR.wr & (CFG_WR.addr < `MCMB_RSVD_ADDR) & ~sys_clr_r; // [R7] [R20] [R22]
  assign fuse_wr_nxt = cfg_ok & mode_r[MCMB_M_WE]; // [R14]

  mcmb_shadow #(
    .N(`MCMB_CFG_BITS)
  ) u_shadow (
    .clk(MCLK),
    .rst_n(RST_N),
    .wr(cfg_ok),
    .addr(CFG_WR.addr),
    .data(CFG_WR.data),
    .rdata(shadow)
  );

  always_comb begin
    eff = mode_r[MCMB_M_SRC] ? shadow : FUSE_BITS; // [R12]
    eff[`MCMB_RSVD_ADDR] = 1'b0; // [R22]
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      FUSE_WR <= '0;
    end else begin
      FUSE_WR.wr <= fuse_wr_nxt; // [R14]
      FUSE_WR.addr <= CFG_WR.addr;
      FUSE_WR.data <= CFG_WR.data;
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  mcmb_cfg_t cfg;
  assign cfg.trim = {eff[`MCMB_TRIM_MSB], eff[`MCMB_TRIM_LSB]}; // [R6]
  assign cfg.nominal_voltage_sel = {eff[`MCMB_NOM_MSB], eff[`MCMB_NOM_LSB]}; // [R6]
  assign cfg.gain = eff[`MCMB_GAIN_ADDR];
  assign cfg.tamper = eff[`MCMB_TAMPER_ADDR];
  assign cfg.stepper = eff[`MCMB_STEPPER_ADDR];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_OUT <= '0;
      CFG_BITS <= '0;
      OSC_ADJ <= MCMB_ADJ_NONE;
      NOMINAL_COEFF <= `MCMB_COEFF_0;
      EXTRA_CURRENT_GAIN <= 4'h0;
      TAMPER_THRESH <= `MCMB_THR_WIDE;
    end else begin
      CFG_OUT <= cfg;
      CFG_BITS <= eff; // [R7]
      case (cfg.trim)
        2'b01: OSC_ADJ <= MCMB_ADJ_PLUS; // [R1]
        2'b10: OSC_ADJ <= MCMB_ADJ_MINUS; // [R1]
        default: OSC_ADJ <= MCMB_ADJ_NONE; // [R1]
      endcase
      case (cfg.nominal_voltage_sel)
        2'b00: NOMINAL_COEFF <= `MCMB_COEFF_0; // [R2]
        2'b01: NOMINAL_COEFF <= `MCMB_COEFF_1; // [R2]
        2'b10: NOMINAL_COEFF <= `MCMB_COEFF_2; // [R2]
        default: NOMINAL_COEFF <= `MCMB_COEFF_3; // [R2]
      endcase
      EXTRA_CURRENT_GAIN <= cfg.gain ? `MCMB_GAIN_EXTRA : 4'h0; // [R3]
      TAMPER_THRESH <= cfg.tamper ? `MCMB_THR_NARROW : `MCMB_THR_WIDE; // [R4]
    end
  end

  // ----------------------------------------
  // mode, record swap and system clear outputs
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      MODE_RECORD <= `MCMB_MODE_RESET;
      RECORD_SWAP <= 1'b0;
      RC_OSC_START <= 1'b0;
      CURRENT_CHANNEL_PICK <= 1'b0;
      FUSE_SENSE_OFF <= 1'b0;
      SYSTEM_SIGNAL_CLEAR <= 1'b0;
    end else begin
      MODE_RECORD <= mode_r;
      RECORD_SWAP <= swap_r;
      RC_OSC_START <= mode_r[MCMB_M_RCOSC]; // [R9]
      CURRENT_CHANNEL_PICK <= mode_r[MCMB_M_CHAN] & ~TAMPER_EN; // [R11]
      FUSE_SENSE_OFF <= mode_r[MCMB_M_SRC]; // [R13] [R19]
      SYSTEM_SIGNAL_CLEAR <= sys_clr_r;
    end
  end

  // ----------------------------------------
  // stepper pulse and charge pump
  // ----------------------------------------
  localparam int PW = 28;
  logic step_busy;
  logic [PW-1:0] step_len;
  logic [15:0] pump_cnt_r;
  logic pump_ph_r;

  assign step_len = cfg.stepper ? PW'(STEP_LONG_CYC) : PW'(STEP_SHORT_CYC); // [R5]

  mcmb_pulse #(
    .W(PW)
  ) u_step (
    .clk(MCLK),
    .rst_n(RST_N),
    .start(STEP_REQ),
    .len(step_len),
    .busy(step_busy)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pump_cnt_r <= 16'h0000;
      pump_ph_r <= 1'b0;
    end else if (!mode_r[MCMB_M_PUMP]) begin
      pump_cnt_r <= 16'h0000;
      pump_ph_r <= 1'b0;
    end else if (pump_cnt_r == PUMP_HALF - 16'h0001) begin
      pump_cnt_r <= 16'h0000;
      pump_ph_r <= ~pump_ph_r;
    end else begin
      pump_cnt_r <= pump_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      MOTOR_OUT_POS <= 1'b0;
      MOTOR_OUT_NEG <= 1'b0;
    end else if (mode_r[MCMB_M_PUMP]) begin
      MOTOR_OUT_POS <= pump_ph_r; // [R10]
      MOTOR_OUT_NEG <= ~pump_ph_r; // [R10]
    end else begin
      MOTOR_OUT_POS <= step_busy; // [R5]
      MOTOR_OUT_NEG <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence set_chan_s;
    cmd_mode && !sys_clr_r && cmd_idx == 3'd4 && cmd_val && !sel_rise;
  endsequence

  sequence chan_seen_s;
    ##1 mode_r[4] ##1 CURRENT_CHANNEL_PICK == !$past(TAMPER_EN);
  endsequence

  rsvd_mode_zero_a: assert property (mode_r[3:2] == 2'b00 && mode_r[7] == 1'b0) // [R22]
    else $error("reserved or swap mode bit stored");
  chan_set_path_a: assert property (set_chan_s |-> chan_seen_s) // [R11]
    else $error("channel select command not applied");
  swap_toggle_a: assert property (cmd_swap |=> swap_r != $past(swap_r)) // [R15]
    else $error("swap command did not toggle order");
  sysclr_block_a: assert property (sys_clr_r && !sel_rise |=> mode_r == $past(mode_r)) // [R18]
    else $error("mode changed while system clear held");
  sysclr_effect_a: assert property (sys_clr_r && sel_rise |=> mode_r == 8'h00 && !sys_clr_r) // [R17]
    else $error("system clear did not wipe mode bits");
  fuse_wr_gate_a: assert property (FUSE_WR.wr |-> $past(mode_r[6]) && $past(cfg_ok)) // [R14]
    else $error("fuse written without write enable");
  sense_off_a: assert property ($rose(mode_r[5]) |=> FUSE_SENSE_OFF) // [R13]
    else $error("sense amplifiers still connected");
  idle_ignore_a: assert property (idle && !sys_clr_r |=> mode_r == $past(mode_r)) // [R21]
    else $error("mode changed while serial idle");
  trim_decode_a: assert property (cfg.trim == 2'b11 |=> OSC_ADJ == MCMB_ADJ_NONE) // [R1]
    else $error("trim code three not neutral");
endmodule

// ==== include/mcmb_map.svh ====
`ifndef MCMB_MAP_SVH
`define MCMB_MAP_SVH
// ----------------------------------------
// configuration bit addresses
// ----------------------------------------
`define MCMB_CFG_BITS 56
`define MCMB_TRIM_LSB 6'h30
`define MCMB_TRIM_MSB 6'h31
`define MCMB_NOM_LSB 6'h32
`define MCMB_NOM_MSB 6'h33
`define MCMB_GAIN_ADDR 6'h34
`define MCMB_TAMPER_ADDR 6'h35
`define MCMB_STEPPER_ADDR 6'h36
`define MCMB_RSVD_ADDR 6'h37
`define MCMB_SYSCLR_ADDR 6'h3F
// ----------------------------------------
// mode command layout
// ----------------------------------------
`define MCMB_CMD_VAL_BIT 7
`define MCMB_CMD_TAG 3'h7
`define MCMB_CMD_SWAP 8'hFF
`define MCMB_MODE_RESET 8'h00
`define MCMB_MODE_RSVD_MASK 8'h0C
// ----------------------------------------
// decoded values
// ----------------------------------------
`define MCMB_COEFF_0 16'h5C01
`define MCMB_COEFF_1 16'h63FE
`define MCMB_COEFF_2 16'h6C02
`define MCMB_COEFF_3 16'h73FE
`define MCMB_GAIN_EXTRA 4'h8
`define MCMB_THR_WIDE 11'h4E2
`define MCMB_THR_NARROW 11'h271
// ----------------------------------------
// timing
// ----------------------------------------
`define MCMB_CLK_NS 10
`define MCMB_STEP_SHORT_NS 31250000
`define MCMB_STEP_LONG_NS 156250000
`define MCMB_PUMP_HALF_CYC 16'h0032
`endif

// ==== include/mcmb_pkg.sv ====
package mcmb_pkg;
  typedef enum logic [1:0] {
    MCMB_ADJ_NONE = 2'b00,
    MCMB_ADJ_PLUS = 2'b01,
    MCMB_ADJ_MINUS = 2'b10
  } mcmb_adj_t;

  typedef enum logic [2:0] {
    MCMB_M_RCOSC = 3'd0,
    MCMB_M_PUMP = 3'd1,
    MCMB_M_CHAN = 3'd4,
    MCMB_M_SRC = 3'd5,
    MCMB_M_WE = 3'd6,
    MCMB_M_SWAP = 3'd7
  } mcmb_mode_idx_t;

  typedef struct packed {
    logic [1:0] trim;
    logic [1:0] nominal_voltage_sel;
    logic gain;
    logic tamper;
    logic stepper;
  } mcmb_cfg_t;

  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic data;
  } mcmb_bitwr_t;

  typedef enum logic {
    MCMB_P_IDLE = 1'b0,
    MCMB_P_BUSY = 1'b1
  } mcmb_pstate_t;
endpackage

// ==== hdl/mcmb_shadow.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// shadow latches, registered read
// ----------------------------------------
module mcmb_shadow #(
  parameter int N = 56
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [5:0] addr,
  input wire logic data,
  output logic [N-1:0] rdata
);
  logic [N-1:0] mem_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r <= '0;
    end else if (wr && (int'(addr) < N)) begin
      mem_r[addr] <= data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r;
    end
  end
endmodule

// ==== hdl/mcmb_pulse.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// one-shot pulse of programmable width
// ----------------------------------------
module mcmb_pulse #(
  parameter int W = 28
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] len,
  output logic busy
);
  import mcmb_pkg::*;
  mcmb_pstate_t st_r;
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= MCMB_P_IDLE;
      cnt_r <= '0;
    end else begin
      case (st_r)
        MCMB_P_IDLE: begin
          if (start) begin
            st_r <= MCMB_P_BUSY;
            cnt_r <= len - W'(1);
          end
        end
        MCMB_P_BUSY: begin
          if (cnt_r == '0) begin
            st_r <= MCMB_P_IDLE;
          end else begin
            cnt_r <= cnt_r - W'(1);
          end
        end
        default: st_r <= MCMB_P_IDLE;
      endcase
    end
  end

  assign busy = (st_r == MCMB_P_BUSY);
endmodule

// ==== dv/mcmb_host.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// host side of the serial command path
// ----------------------------------------
module mcmb_host (
  input wire logic clk,
  output logic sel_n,
  output logic mode_line,
  output logic sclk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output mcmb_pkg::mcmb_bitwr_t cfg_wr,
  output logic read_done
);
  import mcmb_pkg::*;
  initial begin
    sel_n = 1'b1; // all lines high outside frames
    mode_line = 1'b1;
    sclk = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cfg_wr = '0;
    read_done = 1'b0;
  end
  // idle_mode keeps select, mode and clock high while strobing a byte
  task automatic cmd(input logic [7:0] b, input logic idle_mode = 1'b0);
    @(posedge clk);
    sel_n <= idle_mode;
    mode_line <= idle_mode;
    sclk <= idle_mode;
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask
  task automatic wbit(input logic [5:0] a, input logic d);
    @(posedge clk);
    sel_n <= 1'b0;
    mode_line <= 1'b0;
    sclk <= 1'b0;
    cfg_wr <= '{1'b1, a, d}; // six-bit address is the bit index
    @(posedge clk);
    cfg_wr <= '{1'b0, ~a, ~d};
  endtask
  task automatic close;
    @(posedge clk);
    sel_n <= 1'b1;
    mode_line <= 1'b1;
    sclk <= 1'b1;
  endtask
  task automatic done_read;
    @(posedge clk);
    read_done <= 1'b1;
    @(posedge clk);
    read_done <= 1'b0;
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`include "mcmb_map.svh"
module tb;
  import mcmb_pkg::*;
  logic MCLK, RST_N, rr, ten, step, sel_n, ml, sck, cv, rdn, swap, rc, chan, soff, mp, mn, sclr;
  logic [7:0] cb, mode, expm;
  logic [6:0] wlast;
  logic [55:0] fuse, cbits;
  logic [15:0] coeff;
  logic [3:0] gain;
  logic [10:0] thr;
  mcmb_bitwr_t cw, fwr;
  mcmb_cfg_t cfo;
  mcmb_adj_t adj;
  int fails, n_checks, k, cnt, wcnt, bad;
  logic [15:0] ctab [4] = '{`MCMB_COEFF_0, `MCMB_COEFF_1, `MCMB_COEFF_2, `MCMB_COEFF_3};
  logic [7:0] codes [5] = '{8'hF1, 8'hF2, 8'hF9, 8'hFA, 8'hFD};
  mcmb_top #(.STEP_SHORT_CYC(20), .STEP_LONG_CYC(50), .PUMP_HALF(16'h0004)) mcmb_top_inst (
    .MCLK(MCLK), .RST_N(RST_N), .SERIAL_SELECT_N(sel_n), .SERIAL_MODE_LINE(ml),
    .SERIAL_CLOCK_PIN(sck), .REMOTE_RESET_REQ(rr), .CMD_VALID(cv), .CMD_BYTE(cb),
    .CFG_WR(cw), .FUSE_BITS(fuse), .RECORD_READ_DONE(rdn), .TAMPER_EN(ten), .STEP_REQ(step),
    .CFG_OUT(cfo), .CFG_BITS(cbits), .OSC_ADJ(adj), .NOMINAL_COEFF(coeff),
    .EXTRA_CURRENT_GAIN(gain), .TAMPER_THRESH(thr), .MODE_RECORD(mode), .RECORD_SWAP(swap),
    .RC_OSC_START(rc), .CURRENT_CHANNEL_PICK(chan), .FUSE_SENSE_OFF(soff), .FUSE_WR(fwr),
    .MOTOR_OUT_POS(mp), .MOTOR_OUT_NEG(mn), .SYSTEM_SIGNAL_CLEAR(sclr));
  mcmb_host mcmb_host_inst (.clk(MCLK), .sel_n(sel_n), .mode_line(ml), .sclk(sck),
    .cmd_valid(cv), .cmd_byte(cb), .cfg_wr(cw), .read_done(rdn));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic pulse_len(input int exp);
    @(posedge MCLK);
    step <= 1'b1;
    @(posedge MCLK);
    step <= 1'b0;
    cnt = 0;
    for (k = 0; k < 100; k++) begin
      cyc(1);
      if (mp === 1'b1) cnt++;
    end
    chk(cnt, exp);
  endtask
  always @(posedge MCLK) if (fwr.wr === 1'b1) begin
    wcnt++;
    wlast = {fwr.addr, fwr.data};
  end
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #500us;
    fails++;
    tally_and_finish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RST_N = 1'b0; rr = 1'b0; ten = 1'b0; step = 1'b0; fuse = '0; wcnt = 0;
    fails = 0; n_checks = 0;
    cyc(5);
    chk(mode, 8'h00);
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int v = 0; v < 4; v++) begin
      @(posedge MCLK);
      fuse[49:48] <= v[1:0];
      fuse[51:50] <= v[1:0];
      fuse[52] <= v[0];
      fuse[53] <= v[1];
      cyc(5);
      chk(adj, v == 1 ? MCMB_ADJ_PLUS : v == 2 ? MCMB_ADJ_MINUS : MCMB_ADJ_NONE);
      chk(coeff, ctab[v]);
      chk(gain, v[0] ? 4'h8 : 4'h0);
      chk(thr, v[1] ? 11'h271 : 11'h4E2);
    end
    @(posedge MCLK);
    fuse <= '1;
    cyc(3);
    chk(cbits, 56'h7F_FFFF_FFFF_FFFF);
    chk(cfo, 7'h7F);
    @(posedge MCLK);
    fuse <= '0;
    expm = 8'h00;
    for (int i = 0; i < 5; i++) begin
      mcmb_host_inst.cmd(codes[i]);
      expm[codes[i][3:1]] = 1'b1;
      cyc(3);
      chk(mode, expm);
    end
    chk({rc, soff, chan}, 3'b111);
    @(posedge MCLK);
    ten <= 1'b1;
    cyc(3);
    chk(chan, 1'b0);
    mcmb_host_inst.cmd(8'hF4);
    mcmb_host_inst.cmd(8'hF7);
    mcmb_host_inst.cmd(8'h60);
    mcmb_host_inst.cmd(8'h70, 1'b1);
    @(posedge MCLK);
    rr <= 1'b1;
    @(posedge MCLK);
    rr <= 1'b0;
    cyc(3);
    chk(mode, expm);
    for (int i = 0; i < 5; i++) begin
      mcmb_host_inst.cmd({1'b0, codes[i][6:1], ~codes[i][0]});
    end
    cyc(3);
    chk(mode, 8'h00);
    mcmb_host_inst.cmd(8'hFA);
    mcmb_host_inst.wbit(6'h30, 1'b1);
    mcmb_host_inst.wbit(6'h37, 1'b1);
    cyc(5);
    chk(adj, MCMB_ADJ_PLUS);
    chk({cbits[55], cbits[48]}, 2'b01);
    chk(cfo, 7'h20);
    chk(wcnt, 0);
    mcmb_host_inst.cmd(8'hFC); // fuse write enable set before burning, sense stays off
    mcmb_host_inst.wbit(6'h32, 1'b1);
    cyc(4);
    chk(wcnt, 1);
    chk(fwr.wr, 1'b0);
    chk(wlast, {6'h32, 1'b1});
    chk(coeff, `MCMB_COEFF_1);
    chk(soff, 1'b1);
    mcmb_host_inst.cmd(8'hFF);
    cyc(3);
    chk({swap, mode[7]}, 2'b10);
    mcmb_host_inst.cmd(8'hFE);
    cyc(3);
    chk(swap, 1'b0);
    mcmb_host_inst.cmd(8'hFF); // resent before this read
    cyc(3);
    chk(swap, 1'b1);
    mcmb_host_inst.done_read();
    cyc(3);
    chk(swap, 1'b0);
    mcmb_host_inst.wbit(6'h3F, 1'b1);
    cyc(3);
    chk(sclr, 1'b1);
    mcmb_host_inst.cmd(8'hF1);
    mcmb_host_inst.cmd(8'hFF);
    cyc(3);
    chk({swap, mode[0]}, 2'b10);
    mcmb_host_inst.close();
    cyc(4);
    chk({sclr, mode}, 9'h000);
    @(posedge MCLK);
    rr <= 1'b1;
    @(posedge MCLK);
    rr <= 1'b0;
    cyc(3);
    chk({swap, mode}, 9'h000);
    pulse_len(20);
    @(posedge MCLK);
    fuse[54] <= 1'b1;
    cyc(4);
    pulse_len(50);
    mcmb_host_inst.cmd(8'hF2);
    cyc(3);
    cnt = 0;
    bad = 0;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (mn === mp) bad++;
      if (mn === 1'b1) cnt++;
    end
    chk(bad, 0);
    chk(cnt, 20);
    chk(mode, 8'h02);
    @(posedge MCLK);
    RST_N <= 1'b0;
    cyc(2);
    chk({mode, mp, mn}, 10'h000);
    @(posedge MCLK);
    RST_N <= 1'b1;
    cyc(3);
    chk({mode, swap}, 9'h000);
    tally_and_finish();
  end
endmodule
